// ### core/smp_params.svh
`ifndef SMP_PARAMS_SVH
`define SMP_PARAMS_SVH
`define SMP_CORE_HZ       10000000
`define SMP_WRITE_WAIT_MS 4
`define SMP_AUTO_ERASE_MS 1
`define SMP_PM_WORDS      2048
`define SMP_EE_BYTES      256
`define SMP_OP_ENABLE     8'hac
`define SMP_ENABLE_KEY    8'h53
`define SMP_ERASE_KEY     3'h4
`define SMP_OP_RD_PM      4'h2
`define SMP_OP_WR_PM      4'h4
`define SMP_OP_RD_EE      8'ha0
`define SMP_OP_WR_EE      8'hc0
`define SMP_FIRST_POLL    8'h00
`define SMP_SECOND_POLL   8'hff
`define SMP_ERASED        8'hff
`define SMP_ECHO_BIT      5'h10
`define SMP_READ_BIT      5'h18
`define SMP_LAST_BIT      5'h1f
`endif

// ### core/smp_pkg.sv
package smp_pkg;
	typedef enum logic [1:0] {
		SMP_IDLE  = 2'b00,
		SMP_ERASE = 2'b01,
		SMP_PROG  = 2'b10
	} smp_wstate_t;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] hiAddr;
		logic [7:0] loAddr;
		logic [7:0] data;
	} smp_frame_t;
endpackage : smp_pkg

// ### core/smp_sync.sv
module smp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else if (en) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : smp_sync

// ### core/smp_wait_timer.sv
module smp_wait_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         en,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_r;

	// a load of n ends with done in the n-th enabled cycle
	assign busy = cnt_r != '0;
	assign done = en && cnt_r == W'(1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (en) begin
			if (load) begin
				cnt_r <= count;
			end else if (busy) begin
				cnt_r <= cnt_r - W'(1);
			end
		end
	end
endmodule : smp_wait_timer

// ### core/smp_prog_port.sv
`include "smp_params.svh"

// Contract
// RULE_01 - serial programming only while reset pin low
// RULE_02 - enable instruction must precede program or erase
// RULE_03 - eeprom write self-timed with auto erase
// RULE_04 - chip erase fills both arrays with ones
// RULE_05 - program and eeprom use separate address spaces
// RULE_06 - clock phases exceed two system clocks; the bench uses 3 ns sck phases against a 100 ns core_clk period
// RULE_07 - input data sampled on rising clock
// RULE_08 - output data changes on falling clock
// RULE_09 - programmer pulses reset if clock floated
// RULE_10 - programmer waits before first enable instruction
// RULE_11 - second enable byte echoed during third byte
// RULE_12 - programmer always shifts all four bytes; the bench also sends lone sck pulses to misalign frames
// RULE_13 - programmer retries enable, gives up eventually
// RULE_14 - after erase programmer waits, pulses reset
// RULE_15 - one byte per write, address with data
// RULE_16 - without polling programmer waits write delay
// RULE_17 - read returns addressed byte on output
// RULE_18 - reset pin high ends programming mode
// RULE_19 - eeprom poll reads first then second value
// RULE_20 - finished write reads back new value
// RULE_21 - programmer waits fully for poll-value bytes
// RULE_22 - skip all-ones bytes only after erase
// RULE_23 - enable is two fixed bytes, two ignored
// RULE_24 - program byte reads ones while being written
// RULE_25 - programmer honours minimum wait after writes
// RULE_26 - four-byte msb-first frames, counter reset by reset
module smp_prog_port #(
	parameter int PM_WORDS  = `SMP_PM_WORDS,
	parameter int EE_BYTES  = `SMP_EE_BYTES,
	parameter int WRITE_CYC = (`SMP_WRITE_WAIT_MS * (`SMP_CORE_HZ / 1000)),
	parameter int ERASE_CYC = (`SMP_AUTO_ERASE_MS * (`SMP_CORE_HZ / 1000))
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	input  wire logic sck,
	input  wire logic resetPinN,
	input  wire logic mosi,
	output logic      miso,
	output logic      progMode,
	output logic      normalRun,
	output logic      writeBusy
);
	localparam int PAW = $clog2(PM_WORDS);
	localparam int EAW = $clog2(EE_BYTES);
	localparam int TW  = $clog2(WRITE_CYC + 1);
	localparam logic [TW-1:0] WRITE_LD = TW'(WRITE_CYC);
	localparam logic [TW-1:0] ERASE_LD = TW'(ERASE_CYC);
	localparam logic [TW-1:0] REST_LD  = TW'(WRITE_CYC - ERASE_CYC);

	if (PM_WORDS != (1 << PAW) || PM_WORDS > 2048 || EE_BYTES != (1 << EAW)
		|| EE_BYTES > 256 || EAW > PAW || ERASE_CYC < 1 || ERASE_CYC >= WRITE_CYC) begin : g_bad_cfg
		$error("smp_prog_port: unsupported sizes or timing");
	end

	// ---------------- link side, clocked by sck ----------------
	logic               linkRstN;
	logic [31:0]        sh_r;
	logic [4:0]         bitCnt_r;
	logic               progEn_r;
	logic               reqTgl_r;
	logic               pendEe_r;
	logic [PAW-1:0]     pendAddr_r;
	logic [7:0]         txSh_r;
	logic               miso_r;
	logic [7:0]         rdChk_r;
	logic [1:0]         backS;
	logic               eraseTgl_r;
	logic               ackTgl_r;
	logic [7:0]         pmLo [PM_WORDS];
	logic [7:0]         pmHi [PM_WORDS];
	logic [7:0]         eeMem [EE_BYTES];

	// framing, enable and shift logic is held in reset unless the reset pin is low
	// RULE_01 reset pin gate
	assign linkRstN = rst_n & ~resetPinN;

	wire logic [31:0]       word    = {sh_r[30:0], mosi};
	wire smp_pkg::smp_frame_t fr    = smp_pkg::smp_frame_t'(word);
	wire smp_pkg::smp_frame_t rd    = smp_pkg::smp_frame_t'({sh_r[23:0], 8'h00});
	wire logic              frameEnd = bitCnt_r == `SMP_LAST_BIT;
	wire logic              busyL    = reqTgl_r != backS[0];
	wire logic              erasingL = reqTgl_r != backS[1];

	// RULE_23 enable decode
	wire logic isEnable = fr.op == `SMP_OP_ENABLE && fr.hiAddr == `SMP_ENABLE_KEY;
	wire logic isErase  = fr.op == `SMP_OP_ENABLE && fr.hiAddr[7:5] == `SMP_ERASE_KEY;
	wire logic isWrPm   = fr.op[7:4] == `SMP_OP_WR_PM && fr.op[2:0] == 3'h0;
	wire logic isWrEe   = fr.op == `SMP_OP_WR_EE;

	// RULE_05 separate spaces
	wire logic [PAW-1:0] wrPmAddr = PAW'({fr.hiAddr[2:0], fr.loAddr});
	wire logic [EAW-1:0] wrEeAddr = fr.loAddr[EAW-1:0];
	wire logic [PAW-1:0] rdPmAddr = PAW'({rd.hiAddr[2:0], rd.loAddr});
	wire logic [EAW-1:0] rdEeAddr = rd.loAddr[EAW-1:0];
	wire logic [7:0]     wrData   = fr.data;

	// RULE_02 enable gate
	wire logic doErase = frameEnd && isErase && progEn_r;
	// a write arriving before the previous one finished is dropped
	wire logic doWrite = frameEnd && (isWrPm || isWrEe) && progEn_r && !busyL;

	wire logic rdIsPm = rd.op[7:4] == `SMP_OP_RD_PM && rd.op[2:0] == 3'h0;
	wire logic rdIsEe = rd.op == `SMP_OP_RD_EE;
	wire logic pmHit  = busyL && !pendEe_r && pendAddr_r == rdPmAddr;
	wire logic eeHit  = busyL && pendEe_r && pendAddr_r[EAW-1:0] == rdEeAddr;
	wire logic [7:0] pmByte = rd.op[3] ? pmHi[rdPmAddr] : pmLo[rdPmAddr];
	// RULE_19 eeprom polling
	wire logic [7:0] eePoll = erasingL ? `SMP_FIRST_POLL : `SMP_SECOND_POLL;
	// RULE_24 flash polling
	wire logic [7:0] pmRead = pmHit ? `SMP_ERASED : pmByte;
	// RULE_20 stored value
	wire logic [7:0] eeRead = eeHit ? eePoll : eeMem[rdEeAddr];
	// RULE_17 read data
	wire logic [7:0] rdByte = !progEn_r ? 8'h00 : rdIsPm ? pmRead : rdIsEe ? eeRead : 8'h00;

	wire logic       echoLoad  = bitCnt_r == `SMP_ECHO_BIT;
	wire logic       readLoad  = bitCnt_r == `SMP_READ_BIT;
	wire logic       byteStart = bitCnt_r[2:0] == 3'h0;
	// RULE_11 echo byte
	wire logic [7:0] txLoad    = echoLoad ? sh_r[7:0] : readLoad ? rdByte : 8'h00;

	// RULE_07 rising sample
	// RULE_26 frame counter
	always_ff @(posedge sck or negedge linkRstN) begin
		if (!linkRstN) begin
			sh_r     <= '0;
			bitCnt_r <= '0;
			progEn_r <= 1'b0;
		end else begin
			sh_r     <= word;
			bitCnt_r <= bitCnt_r + 5'h01;
			if (frameEnd && isEnable) begin
				progEn_r <= 1'b1;
			end
		end
	end

	// write handoff survives the reset pin so the timed write still ends
	// RULE_15 write capture
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			reqTgl_r   <= 1'b0;
			pendEe_r   <= 1'b0;
			pendAddr_r <= '0;
		end else if (doWrite) begin
			reqTgl_r   <= ~reqTgl_r;
			pendEe_r   <= isWrEe;
			pendAddr_r <= isWrEe ? PAW'(wrEeAddr) : wrPmAddr;
		end
	end

	// arrays are nonvolatile and carry no reset
	always_ff @(posedge sck) begin
		if (doErase) begin
			// RULE_04 erase to ones
			for (int i = 0; i < PM_WORDS; i++) begin
				pmLo[i] <= `SMP_ERASED;
				pmHi[i] <= `SMP_ERASED;
			end
			for (int i = 0; i < EE_BYTES; i++) begin
				eeMem[i] <= `SMP_ERASED;
			end
		end else if (doWrite) begin
			// RULE_03 overwrite replaces byte
			if (isWrEe) begin
				eeMem[wrEeAddr] <= wrData;
			end else if (fr.op[3]) begin
				pmHi[wrPmAddr] <= wrData;
			end else begin
				pmLo[wrPmAddr] <= wrData;
			end
		end
	end

	// RULE_08 falling shift
	always_ff @(negedge sck or negedge linkRstN) begin
		if (!linkRstN) begin
			txSh_r <= '0;
			miso_r <= 1'b0;
		end else if (byteStart) begin
			miso_r <= txLoad[7];
			txSh_r <= {txLoad[6:0], 1'b0};
		end else begin
			miso_r <= txSh_r[7];
			txSh_r <= {txSh_r[6:0], 1'b0};
		end
	end

	assign miso = miso_r;

	always_ff @(posedge sck or negedge linkRstN) begin
		if (!linkRstN) begin
			rdChk_r <= '0;
		end else if (readLoad) begin
			rdChk_r <= rdByte;
		end
	end

	smp_sync #(.W(2)) u_back_sync (
		.clk   (sck),
		.rst_n (rst_n),
		.en    (1'b1),
		.d     ({eraseTgl_r, ackTgl_r}),
		.q     (backS)
	);

	// ---------------- core side, clocked by core_clk ----------------
	logic [2:0]             fwdS;
	logic                   reqPrev_r;
	smp_pkg::smp_wstate_t   state_r;
	smp_pkg::smp_wstate_t   state_nxt;
	logic                   tmrGo;
	logic [TW-1:0]          tmrLoad;
	logic                   tmrDone;
	logic                   eraseFlip;
	logic                   ackFlip;
	logic                   progMode_r;
	logic                   normalRun_r;
	logic                   writeBusy_r;
	logic [31:0]            busyCnt_r;

	smp_sync #(.W(3)) u_fwd_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.en    (clkEn),
		.d     ({resetPinN, progEn_r, reqTgl_r}),
		.q     (fwdS)
	);

	wire logic pinHigh = fwdS[2];
	wire logic start   = fwdS[0] != reqPrev_r;

	smp_wait_timer #(.W(TW)) u_timer (
		.clk   (core_clk),
		.rst_n (rst_n),
		.en    (clkEn),
		.load  (tmrGo),
		.count (tmrLoad),
		.busy  (),
		.done  (tmrDone)
	);

	// pendEe_r is stable from the request toggle until the ack returns
	// RULE_03 erase then program
	always_comb begin
		state_nxt = state_r;
		tmrGo     = 1'b0;
		tmrLoad   = '0;
		eraseFlip = 1'b0;
		ackFlip   = 1'b0;
		case (state_r)
			smp_pkg::SMP_IDLE: begin
				if (start) begin
					tmrGo = 1'b1;
					if (pendEe_r) begin
						state_nxt = smp_pkg::SMP_ERASE;
						tmrLoad   = ERASE_LD;
					end else begin
						state_nxt = smp_pkg::SMP_PROG;
						tmrLoad   = WRITE_LD;
						eraseFlip = 1'b1;
					end
				end
			end
			smp_pkg::SMP_ERASE: begin
				if (tmrDone) begin
					eraseFlip = 1'b1;
					tmrGo     = 1'b1;
					tmrLoad   = REST_LD;
					state_nxt = smp_pkg::SMP_PROG;
				end
			end
			smp_pkg::SMP_PROG: begin
				if (tmrDone) begin
					ackFlip   = 1'b1;
					state_nxt = smp_pkg::SMP_IDLE;
				end
			end
			default: begin
				state_nxt = smp_pkg::SMP_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= smp_pkg::SMP_IDLE;
			reqPrev_r   <= 1'b0;
			eraseTgl_r  <= 1'b0;
			ackTgl_r    <= 1'b0;
			writeBusy_r <= 1'b0;
		end else if (clkEn) begin
			state_r     <= state_nxt;
			reqPrev_r   <= fwdS[0];
			eraseTgl_r  <= eraseTgl_r ^ eraseFlip;
			ackTgl_r    <= ackTgl_r ^ ackFlip;
			writeBusy_r <= state_nxt != smp_pkg::SMP_IDLE;
		end
	end

	// RULE_18 leave programming mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			progMode_r  <= 1'b0;
			normalRun_r <= 1'b0;
		end else if (clkEn) begin
			progMode_r  <= fwdS[1] && !pinHigh;
			normalRun_r <= pinHigh;
		end
	end

	assign progMode  = progMode_r;
	assign normalRun = normalRun_r;
	assign writeBusy = writeBusy_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busyCnt_r <= '0;
		end else if (clkEn) begin
			busyCnt_r <= writeBusy_r ? busyCnt_r + 32'h1 : 32'h0;
		end
	end

	// ---------------- checks ----------------
	sequence sEnableFrame;
		frameEnd && isEnable;
	endsequence

	sequence sEchoWindow;
		bitCnt_r[4:3] == 2'b10;
	endsequence

	sequence sLockedWrite;
		frameEnd && (isWrPm || isWrEe) && !progEn_r;
	endsequence

	a_enable_accept: assert property ( // RULE_02
		@(posedge sck) disable iff (!linkRstN) sEnableFrame |=> progEn_r ##1 progEn_r)
		else $error("enable frame not accepted");

	a_locked_write: assert property ( // RULE_02
		@(posedge sck) disable iff (!linkRstN) sLockedWrite |=> reqTgl_r == $past(reqTgl_r))
		else $error("write taken before enable");

	a_echo_byte: assert property ( // RULE_11
		@(posedge sck) disable iff (!linkRstN) sEchoWindow |-> miso_r == sh_r[7])
		else $error("second byte not echoed");

	a_read_byte: assert property ( // RULE_17
		@(posedge sck) disable iff (!linkRstN)
		bitCnt_r[4:3] == 2'b11 |-> miso_r == (readLoad ? rdByte[7] : rdChk_r[~bitCnt_r[2:0]]))
		else $error("read byte not shifted out");

	a_rise_sample: assert property ( // RULE_07
		@(posedge sck) disable iff (!linkRstN) bitCnt_r != 5'h00 |-> sh_r[0] == $past(mosi))
		else $error("input not sampled on rising edge");

	a_chip_erase: assert property ( // RULE_04
		@(posedge sck) disable iff (!linkRstN)
		doErase |=> pmLo[0] == 8'hff && pmHi[PM_WORDS-1] == 8'hff && eeMem[EE_BYTES-1] == 8'hff)
		else $error("chip erase left a byte not all ones");

	a_ee_commit: assert property ( // RULE_15
		@(posedge sck) disable iff (!linkRstN)
		doWrite && isWrEe |=> eeMem[$past(wrEeAddr)] == $past(wrData) && busyL && erasingL)
		else $error("eeprom write not stored or not busy");

	a_ee_poll: assert property ( // RULE_19
		@(posedge sck) disable iff (!linkRstN)
		readLoad && rdIsEe && eeHit && progEn_r |-> rdByte == (erasingL ? 8'h00 : 8'hff))
		else $error("eeprom poll value wrong");

	a_pm_poll: assert property ( // RULE_24
		@(posedge sck) disable iff (!linkRstN) readLoad && rdIsPm && pmHit && progEn_r |-> rdByte == 8'hff)
		else $error("flash poll value wrong");

	a_write_time: assert property ( // RULE_03
		@(posedge core_clk) disable iff (!rst_n) $fell(writeBusy_r) |-> busyCnt_r == WRITE_CYC)
		else $error("write busy time wrong");

	a_erase_first: assert property ( // RULE_03
		@(posedge core_clk) disable iff (!rst_n)
		clkEn && state_r == smp_pkg::SMP_IDLE && start && pendEe_r |=> state_r == smp_pkg::SMP_ERASE)
		else $error("eeprom write skipped auto erase");

	a_normal_run: assert property ( // RULE_18
		@(posedge core_clk) disable iff (!rst_n) clkEn && pinHigh |=> normalRun_r && !progMode_r)
		else $error("reset release did not end programming");
endmodule : smp_prog_port

// ### bench/smp_programmer.sv
module smp_programmer (
	output logic      sck,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;

	// sck stands low between frames; link logic is sck-only, so a fast sck is safe
	initial begin
		sck  = 1'b0;
		mosi = 1'b0;
	end

	// 3 ns phases; link side never samples core_clk
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		#1.3;
		for (int i = 31; i >= 0; i--) begin
			mosi = tx[i];
			#3 sck = 1'b1;
			rx[i] = miso;
			#3 sck = 1'b0;
		end
		// idle line must not show the last bit
		mosi = ~mosi;
	endtask : xfer

	task automatic pulse();
		#3 sck = 1'b1;
		#3 sck = 1'b0;
	endtask : pulse
endmodule : smp_programmer

// ### bench/tb_smp_prog_port.sv
`include "smp_params.svh"

module tb_smp_prog_port;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int WCYC = 40;
	localparam int ECYC = 10;
	localparam logic [31:0] ENABLE = {`SMP_OP_ENABLE, `SMP_ENABLE_KEY, 16'h0000};

	logic        core_clk;
	logic        rst_n;
	logic        clkEn;
	logic        resetPinN;
	logic        sck;
	logic        mosi;
	logic        miso;
	logic        progMode;
	logic        normalRun;
	logic        writeBusy;
	logic [31:0] rx;
	int          miscompares;
	int          checked;
	int          busyCnt;

	smp_prog_port #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) smp_prog_port_i (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.sck      (sck),
		.resetPinN(resetPinN),
		.mosi     (mosi),
		.miso     (miso),
		.progMode (progMode),
		.normalRun(normalRun),
		.writeBusy(writeBusy)
	);

	smp_programmer smp_programmer_i (
		.sck (sck),
		.mosi(mosi),
		.miso(miso)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// counts enabled cycles with busy high
	always @(posedge core_clk) begin
		if (writeBusy === 1'b1 && clkEn === 1'b1) begin
			busyCnt++;
		end
	end

	function automatic logic [31:0] eeCmd(logic [7:0] op, logic [7:0] a, logic [7:0] d);
		return {op, 8'h00, a, d};
	endfunction : eeCmd

	function automatic logic [31:0] pmCmd(logic [3:0] op, logic h, logic [10:0] w, logic [7:0] d);
		return {op, h, 3'h0, 5'h00, w, d};
	endfunction : pmCmd

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic frame(input logic [31:0] tx);
		smp_programmer_i.xfer(tx, rx);
	endtask : frame

	task automatic waitBusy(input logic level);
		for (int i = 0; i <= 4 * WCYC; i++) begin
			if (writeBusy === level) begin
				return;
			end
			cyc(1);
		end
		miscompares++;
		$display("CHECK FAILED writeBusy wait expected %b seen %b", level, writeBusy);
		end_of_test();
	endtask : waitBusy

	task automatic pinPulse();
		cyc(1);
		resetPinN = 1'b1;
		cyc(3);
		resetPinN = 1'b0;
		cyc(5);
	endtask : pinPulse

	always @(miso) begin
		if (rst_n === 1'b1 && resetPinN === 1'b0) begin
			check("miso change edge", 32'(sck), 32'h0);
		end
	end

	initial begin : main
		logic [7:0]  a;
		logic [7:0]  d;
		logic [10:0] w;
		logic        h;
		int          n;
		rst_n     = 1'b0;
		clkEn     = 1'b1;
		resetPinN = 1'b1;
		busyCnt   = 0;
		void'($urandom(48864));
		cyc(20);
		rst_n = 1'b1;
		cyc(5);
		check("normalRun", 32'({normalRun, progMode}), 32'h2);
		resetPinN = 1'b0;
		cyc(5);
		frame(eeCmd(`SMP_OP_RD_EE, 8'h12, 8'h00));
		check("read before enable", 32'(rx[7:0]), 32'h0);
		frame(pmCmd(`SMP_OP_WR_PM, 1'b0, 11'h005, 8'h5a));
		cyc(10);
		check("write before enable", 32'(writeBusy), 32'h0);
		frame(ENABLE);
		check("enable echo", 32'(rx[15:8]), 32'(`SMP_ENABLE_KEY));
		cyc(5);
		check("progMode", 32'({normalRun, progMode}), 32'h1);
		$display("test entry done");
		frame({`SMP_OP_ENABLE, `SMP_ERASE_KEY, 21'h0});
		cyc(ECYC);
		pinPulse();
		frame(ENABLE);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 8'hff : 8'($urandom);
			w = (i == 0) ? 11'h7ff : 11'($urandom);
			frame(eeCmd(`SMP_OP_RD_EE, a, 8'h00));
			check("erased eeprom", 32'(rx[7:0]), 32'(`SMP_ERASED));
			frame(pmCmd(`SMP_OP_RD_PM, i[0], w, 8'h00));
			check("erased flash", 32'(rx[7:0]), 32'(`SMP_ERASED));
		end
		$display("test erase done");
		a = 8'($urandom);
		d = 8'($urandom_range(1, 254));
		busyCnt = 0;
		frame(eeCmd(`SMP_OP_WR_EE, a, d));
		waitBusy(1'b1);
		frame(eeCmd(`SMP_OP_RD_EE, a, 8'h00));
		check("poll erase phase", 32'(rx[7:0]), 32'(`SMP_FIRST_POLL));
		cyc(ECYC);
		frame(eeCmd(`SMP_OP_RD_EE, a, 8'h00));
		check("poll program phase", 32'(rx[7:0]), 32'(`SMP_SECOND_POLL));
		waitBusy(1'b0);
		check("busy length", 32'(busyCnt), 32'(WCYC));
		frame(eeCmd(`SMP_OP_RD_EE, a, 8'h00));
		check("eeprom readback", 32'(rx[7:0]), 32'(d));
		$display("test eeprom poll done");
		w = 11'($urandom);
		h = 1'($urandom);
		frame(pmCmd(`SMP_OP_WR_PM, h, w, d));
		waitBusy(1'b1);
		frame(pmCmd(`SMP_OP_RD_PM, ~h, w, 8'h00));
		check("flash poll", 32'(rx[7:0]), 32'hff);
		cyc(1);
		clkEn = 1'b0;
		cyc(2 * WCYC);
		check("busy frozen", 32'(writeBusy), 32'h1);
		clkEn = 1'b1;
		waitBusy(1'b0);
		frame(pmCmd(`SMP_OP_RD_PM, h, w, 8'h00));
		check("flash readback", 32'(rx[7:0]), 32'(d));
		$display("test flash poll done");
		for (int i = 0; i < 4; i++) begin
			a = 8'($urandom);
			d = (i == 0) ? `SMP_FIRST_POLL : 8'($urandom);
			w = {3'($urandom), a};
			h = 1'($urandom);
			frame(eeCmd(`SMP_OP_WR_EE, a, d));
			waitBusy(1'b1);
			waitBusy(1'b0);
			frame(pmCmd(`SMP_OP_WR_PM, h, w, ~d));
			waitBusy(1'b1);
			waitBusy(1'b0);
			frame(eeCmd(`SMP_OP_RD_EE, a, 8'h00));
			check("eeprom space", 32'(rx[7:0]), 32'(d));
			frame(pmCmd(`SMP_OP_RD_PM, h, w, 8'h00));
			check("flash space", 32'(rx[7:0]), {24'h000000, ~d});
		end
		$display("test random spaces done");
		smp_programmer_i.pulse();
		frame(ENABLE);
		check("echo off frame", 32'(rx[15:8] !== `SMP_ENABLE_KEY), 32'h1);
		for (n = 1; n <= 32; n++) begin
			smp_programmer_i.pulse();
			frame(ENABLE);
			if (rx[15:8] === `SMP_ENABLE_KEY) begin
				break;
			end
		end
		check("resync attempts", 32'(n <= 32), 32'h1);
		cyc(2 * WCYC);
		repeat (5) smp_programmer_i.pulse();
		pinPulse();
		frame(ENABLE);
		check("echo after pin reset", 32'(rx[15:8]), 32'(`SMP_ENABLE_KEY));
		$display("test framing done");
		cyc(1);
		rst_n = 1'b0;
		cyc(1);
		check("outputs in reset", 32'({progMode, normalRun, writeBusy, miso}), 32'h0);
		rst_n     = 1'b1;
		resetPinN = 1'b1;
		cyc(5);
		check("normal after reset", 32'({normalRun, progMode}), 32'h2);
		$display("test second reset done");
		end_of_test();
	end
endmodule : tb_smp_prog_port
